// ### sbl_pkg.sv
// constants, enumerations and carrier types for the serial boot loader link
// assumes a single 100 MHz core clock and host pins already synchronous to it
package sbl_pkg;

	// ==========================================================
	// protocol bytes
	localparam logic [7:0] ACK_BYTE = 8'hcc;
	localparam logic [7:0] NAK_BYTE = 8'h33;
	localparam logic [7:0] PAD_BYTE = 8'h00;
	localparam logic [7:0] CMD_PING = 8'h20;
	localparam logic [7:0] CMD_DOWNLOAD = 8'h21;
	localparam logic [7:0] CMD_RUN = 8'h22;
	localparam logic [7:0] CMD_STATUS = 8'h23;
	localparam logic [7:0] CMD_SEND_DATA = 8'h24;
	localparam logic [7:0] CMD_RESET = 8'h25;
	localparam logic [7:0] HDR_LEN = 8'h02;
	localparam logic [7:0] MIN_PKT_LEN = 8'h03;
	localparam logic [7:0] DL_PKT_LEN = 8'h0b;
	localparam logic [7:0] STATUS_PKT_LEN = 8'h03;

	// status codes (plain defaults)
	localparam logic [7:0] STAT_SUCCESS = 8'h01;
	localparam logic [7:0] STAT_UNKNOWN = 8'h02;
	localparam logic [7:0] STAT_BAD_LEN = 8'h03;

	// ==========================================================
	// rate detection, character timing and fifo shape
	localparam logic [3:0] AB_MEAS_EDGES = 4'h5;
	localparam logic [3:0] AB_ALL_EDGES = 4'ha;
	localparam int AB_MEAS_SHIFT = 3;
	localparam logic [3:0] UART_STOP_BIT = 4'h9;
	localparam logic [2:0] SSI_FIRST_BIT = 3'h0;
	localparam logic [2:0] SSI_LAST_BIT = 3'h7;
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 8;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		LK_NONE = 2'b00,
		LK_UART = 2'b01,
		LK_SSI = 2'b10
	} sbl_lock_t;

	typedef enum logic [2:0] {
		E_SIZE = 3'b000,
		E_SUM = 3'b001,
		E_DATA = 3'b010,
		E_REPLY = 3'b011,
		E_TSIZE = 3'b100,
		E_TSUM = 3'b101,
		E_TDATA = 3'b110,
		E_WACK = 3'b111
	} sbl_eng_t;

	typedef struct packed {
		logic [7:0] code;
		logic [31:0] param;
	} sbl_cmd_t;

endpackage

// ### sbl_link.sv
// serial boot loader packet link: byte fifo and the link top
// assumes host pins are synchronous to i_core_clk, sync clock <= clk/12
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// byte fifo; depth must be a power of two
module sbl_byte_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [W-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [W-1:0] o_out_data
);
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW:0] wp;
		logic [AW:0] rp;
	} sbl_fst_t;
	sbl_fst_t st;
	sbl_fst_t next_st;

	assign o_in_ready = !((st.wp[AW] != st.rp[AW]) && (st.wp[AW-1:0] == st.rp[AW-1:0]));
	assign o_out_valid = (st.wp != st.rp);
	assign o_out_data = st.mem[st.rp[AW-1:0]];

	always_comb begin
		next_st = st;
		if (i_in_valid && o_in_ready) begin
			next_st.mem[st.wp[AW-1:0]] = i_in_data;
			next_st.wp = st.wp + 1'b1;
		end
		if (o_out_valid && i_out_ready) begin
			next_st.rp = st.rp + 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule

// ==========================================================
// link top
module sbl_link (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic i_uart_rx,
	output logic o_uart_tx,
	input wire logic i_ssi_clk,
	input wire logic i_ssi_fss_n,
	input wire logic i_ssi_mosi,
	output logic o_ssi_miso,
	output logic o_ssi_miso_oe_n,
	output logic o_cmd_strobe,
	output var sbl_pkg::sbl_cmd_t o_cmd,
	output logic o_prog_load,
	output logic [31:0] o_prog_addr,
	output logic [31:0] o_prog_len,
	output logic [7:0] o_last_status,
	output var sbl_pkg::sbl_lock_t o_link_lock
);
	typedef struct packed {
		sbl_pkg::sbl_lock_t lock;
		logic [3:0] ab_edges;
		logic [18:0] ab_cnt;
		logic [15:0] baud_div;
		logic rx_prev;
		logic urx_busy;
		logic [15:0] urx_cnt;
		logic [3:0] urx_bit;
		logic [7:0] urx_sh;
		logic utx_busy;
		logic [15:0] utx_cnt;
		logic [3:0] utx_bit;
		logic [9:0] utx_sh;
		logic uart_tx;
		logic ssi_prev_clk;
		logic [2:0] ssi_bit;
		logic [7:0] ssi_rsh;
		logic [7:0] ssi_tsh;
		logic miso;
		logic miso_oe_n;
		sbl_pkg::sbl_eng_t pk;
		logic [7:0] pk_len;
		logic [7:0] pk_csum;
		logic [7:0] pk_rsum;
		logic [7:0] pk_left;
		logic [7:0] pk_cmd;
		logic pk_bad;
		logic [63:0] pk_par;
		logic [7:0] status;
		logic cmd_strobe;
		logic prog_load;
		logic [31:0] prog_addr;
		logic [31:0] prog_len;
	} sbl_st_t;

	// edge detectors start at the idle pin levels, so no false edge follows reset
	localparam sbl_st_t ST_RST = '{uart_tx: 1'b1, miso: 1'b1, miso_oe_n: 1'b1, rx_prev: 1'b1,
		ssi_prev_clk: 1'b1, lock: sbl_pkg::LK_NONE, pk: sbl_pkg::E_SIZE, default: '0};

	sbl_st_t st;
	sbl_st_t next_st;
	logic ssi_on, ssi_rise, ssi_fall, rx_fall;
	logic eng_valid, eng_take, eng_rx, uart_rdy, ssi_rdy;
	logic [7:0] eng_data;
	logic [7:0] ssi_byte;
	logic [7:0] ssi_out;
	logic [7:0] rx_byte;
	logic rx_push;
	logic f_in_ready, f_out_valid, f_take;
	logic [7:0] f_out_data;

	// ==========================================================
	// rx byte buffer; engine stalls it while it answers
	sbl_byte_fifo #(.W(sbl_pkg::FIFO_WIDTH), .D(sbl_pkg::FIFO_DEPTH)) u_fifo (
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.i_in_valid(rx_push),
		.o_in_ready(f_in_ready),
		.i_in_data(rx_byte),
		.o_out_valid(f_out_valid),
		.i_out_ready(eng_rx),
		.o_out_data(f_out_data)
	);

	// ==========================================================
	// edges and handshakes
	assign ssi_on = !i_ssi_fss_n && (st.lock != sbl_pkg::LK_UART);
	assign ssi_rise = ssi_on && !st.ssi_prev_clk && i_ssi_clk;
	assign ssi_fall = ssi_on && st.ssi_prev_clk && !i_ssi_clk;
	assign rx_fall = st.rx_prev && !i_uart_rx;
	assign ssi_byte = {st.ssi_rsh[6:0], i_ssi_mosi};
	assign eng_valid = st.pk inside {sbl_pkg::E_REPLY, sbl_pkg::E_TSIZE, sbl_pkg::E_TSUM,
		sbl_pkg::E_TDATA};
	assign eng_data = (st.pk == sbl_pkg::E_REPLY) ?
		(st.pk_bad ? sbl_pkg::NAK_BYTE : sbl_pkg::ACK_BYTE) :
		(st.pk == sbl_pkg::E_TSIZE) ? sbl_pkg::STATUS_PKT_LEN : st.status;
	assign uart_rdy = (st.lock == sbl_pkg::LK_UART) && !st.utx_busy;
	assign ssi_rdy = ssi_fall && (st.ssi_bit == sbl_pkg::SSI_FIRST_BIT) &&
		(st.lock == sbl_pkg::LK_SSI);
	assign eng_take = eng_valid && (uart_rdy || ssi_rdy);
	// idle slave shifts zero padding
	assign ssi_out = (eng_valid && ssi_rdy) ? eng_data : sbl_pkg::PAD_BYTE;
	assign eng_rx = st.pk inside {sbl_pkg::E_SIZE, sbl_pkg::E_SUM, sbl_pkg::E_DATA,
		sbl_pkg::E_WACK};
	assign f_take = f_out_valid && eng_rx;

	always_comb begin
		next_st = st;
		rx_push = 1'b0;
		rx_byte = sbl_pkg::PAD_BYTE;
		next_st.cmd_strobe = 1'b0;
		next_st.prog_load = 1'b0;
		next_st.rx_prev = i_uart_rx;
		next_st.ssi_prev_clk = i_ssi_clk;
		next_st.miso_oe_n = !ssi_on;

		// ======================================================
		// sync slave, mode 3: shift out on fall, sample on rise
		if (i_ssi_fss_n) begin
			next_st.ssi_bit = sbl_pkg::SSI_FIRST_BIT;
		end
		if (ssi_fall) begin
			if (st.ssi_bit == sbl_pkg::SSI_FIRST_BIT) begin
				next_st.miso = ssi_out[7];
				next_st.ssi_tsh = {ssi_out[6:0], 1'b0};
			end else begin
				next_st.miso = st.ssi_tsh[7];
				next_st.ssi_tsh = {st.ssi_tsh[6:0], 1'b0};
			end
		end
		if (ssi_rise) begin
			next_st.ssi_rsh = ssi_byte;
			next_st.ssi_bit = st.ssi_bit + 3'h1;
			if (st.ssi_bit == sbl_pkg::SSI_LAST_BIT) begin
				if (st.lock == sbl_pkg::LK_SSI) begin
					rx_push = 1'b1;
					rx_byte = ssi_byte;
				end else if (ssi_byte != sbl_pkg::PAD_BYTE) begin
					next_st.lock = sbl_pkg::LK_SSI;
					rx_push = 1'b1;
					rx_byte = ssi_byte;
				end
			end
		end

		// ======================================================
		// rate detection: 1st to 5th falling edge spans 8 bits
		if (st.lock == sbl_pkg::LK_NONE) begin
			if (st.ab_edges != 4'h0) begin
				next_st.ab_cnt = st.ab_cnt + 19'h1;
			end
			if (&st.ab_cnt) begin
				// stray pulse; start over
				next_st.ab_edges = 4'h0;
			end else if (rx_fall && st.ab_edges != sbl_pkg::AB_ALL_EDGES) begin
				next_st.ab_edges = st.ab_edges + 4'h1;
				if (st.ab_edges == 4'h0 || st.ab_edges == sbl_pkg::AB_ALL_EDGES - 4'h1) begin
					next_st.ab_cnt = '0;
				end
				if (st.ab_edges == sbl_pkg::AB_MEAS_EDGES - 4'h1) begin
					next_st.baud_div = 16'((st.ab_cnt + 19'h1) >> sbl_pkg::AB_MEAS_SHIFT);
				end
			end else if (st.ab_edges == sbl_pkg::AB_ALL_EDGES &&
				st.ab_cnt == 19'({st.baud_div, 1'b0})) begin
				// let the last stop bit pass, then confirm
				next_st.lock = sbl_pkg::LK_UART;
				next_st.utx_busy = 1'b1;
				next_st.utx_sh = {1'b1, sbl_pkg::ACK_BYTE, 1'b0};
				next_st.uart_tx = 1'b0;
				next_st.utx_bit = 4'h0;
				next_st.utx_cnt = 16'(st.baud_div - 16'h1);
			end
		end

		// ======================================================
		// async receiver, mid-bit sampling
		if (st.lock == sbl_pkg::LK_UART) begin
			if (!st.urx_busy) begin
				if (rx_fall) begin
					next_st.urx_busy = 1'b1;
					next_st.urx_cnt = st.baud_div >> 1;
					next_st.urx_bit = 4'h0;
				end
			end else if (st.urx_cnt != 16'h0) begin
				next_st.urx_cnt = st.urx_cnt - 16'h1;
			end else begin
				next_st.urx_cnt = 16'(st.baud_div - 16'h1);
				next_st.urx_bit = st.urx_bit + 4'h1;
				if (st.urx_bit == 4'h0) begin
					next_st.urx_busy = !i_uart_rx;
				end else if (st.urx_bit < sbl_pkg::UART_STOP_BIT) begin
					next_st.urx_sh = {i_uart_rx, st.urx_sh[7:1]};
				end else begin
					next_st.urx_busy = 1'b0;
					rx_push = i_uart_rx;
					rx_byte = st.urx_sh;
				end
			end
		end

		// ======================================================
		// async transmitter: start, 8 data lsb first, stop
		if (st.utx_busy) begin
			if (st.utx_cnt != 16'h0) begin
				next_st.utx_cnt = st.utx_cnt - 16'h1;
			end else begin
				next_st.utx_cnt = 16'(st.baud_div - 16'h1);
				if (st.utx_bit == sbl_pkg::UART_STOP_BIT) begin
					next_st.utx_busy = 1'b0;
				end else begin
					next_st.utx_bit = st.utx_bit + 4'h1;
					next_st.utx_sh = {1'b1, st.utx_sh[9:1]};
					next_st.uart_tx = st.utx_sh[1];
				end
			end
		end else if (eng_take && uart_rdy) begin
			next_st.utx_busy = 1'b1;
			next_st.utx_sh = {1'b1, eng_data, 1'b0};
			next_st.uart_tx = 1'b0;
			next_st.utx_bit = 4'h0;
			next_st.utx_cnt = 16'(st.baud_div - 16'h1);
		end

		// ======================================================
		// packet engine; bytes may arrive at any pacing
		case (st.pk)
			sbl_pkg::E_SIZE: begin
				if (f_take && f_out_data != sbl_pkg::PAD_BYTE) begin
					next_st.pk_len = f_out_data;
					next_st.pk_rsum = '0;
					next_st.pk_bad = 1'b0;
					next_st.pk = sbl_pkg::E_SUM;
				end
			end
			sbl_pkg::E_SUM: begin
				if (f_take) begin
					next_st.pk_csum = f_out_data;
					next_st.pk_left = 8'(st.pk_len - sbl_pkg::HDR_LEN);
					if (st.pk_len < sbl_pkg::MIN_PKT_LEN) begin
						next_st.pk_bad = 1'b1;
						next_st.pk = sbl_pkg::E_REPLY;
					end else begin
						next_st.pk = sbl_pkg::E_DATA;
					end
				end
			end
			sbl_pkg::E_DATA: begin
				if (f_take) begin
					next_st.pk_rsum = 8'(st.pk_rsum + f_out_data);
					next_st.pk_left = st.pk_left - 8'h1;
					if (st.pk_left == 8'(st.pk_len - sbl_pkg::HDR_LEN)) begin
						next_st.pk_cmd = f_out_data;
					end else begin
						next_st.pk_par = {st.pk_par[55:0], f_out_data};
					end
					if (st.pk_left == 8'h1) begin
						next_st.pk = sbl_pkg::E_REPLY;
						if (8'(st.pk_rsum + f_out_data) != st.pk_csum) begin
							next_st.pk_bad = 1'b1;
						end
					end
				end
			end
			sbl_pkg::E_REPLY: begin
				if (eng_take) begin
					next_st.pk = sbl_pkg::E_SIZE;
					if (!st.pk_bad) begin
						if (st.pk_cmd == sbl_pkg::CMD_PING) begin
							next_st.status = sbl_pkg::STAT_SUCCESS;
						end else if (st.pk_cmd == sbl_pkg::CMD_STATUS) begin
							next_st.pk = sbl_pkg::E_TSIZE;
						end else if (st.pk_cmd == sbl_pkg::CMD_DOWNLOAD) begin
							if (st.pk_len == sbl_pkg::DL_PKT_LEN) begin
								next_st.prog_addr = st.pk_par[63:32];
								next_st.prog_len = st.pk_par[31:0];
								next_st.prog_load = 1'b1;
								next_st.status = sbl_pkg::STAT_SUCCESS;
							end else begin
								next_st.status = sbl_pkg::STAT_BAD_LEN;
							end
						end else if (st.pk_cmd inside {sbl_pkg::CMD_RUN, sbl_pkg::CMD_SEND_DATA,
							sbl_pkg::CMD_RESET}) begin
							// flash and run actions live outside this block
							next_st.cmd_strobe = 1'b1;
							next_st.status = sbl_pkg::STAT_SUCCESS;
						end else begin
							next_st.status = sbl_pkg::STAT_UNKNOWN;
						end
					end
				end
			end
			sbl_pkg::E_TSIZE: begin
				if (eng_take) begin
					next_st.pk = sbl_pkg::E_TSUM;
				end
			end
			sbl_pkg::E_TSUM: begin
				if (eng_take) begin
					next_st.pk = sbl_pkg::E_TDATA;
				end
			end
			sbl_pkg::E_TDATA: begin
				if (eng_take) begin
					next_st.pk = sbl_pkg::E_WACK;
				end
			end
			default: begin
				// host answer; a nak just means it will resend
				if (f_take && f_out_data != sbl_pkg::PAD_BYTE) begin
					next_st.pk = sbl_pkg::E_SIZE;
				end
			end
		endcase

		// lost byte spoils the packet; set wins over the clear above
		if (rx_push && !f_in_ready) begin
			next_st.pk_bad = 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st <= ST_RST;
		end else begin
			st <= next_st;
		end
	end

	assign o_uart_tx = st.uart_tx;
	assign o_ssi_miso = st.miso;
	assign o_ssi_miso_oe_n = st.miso_oe_n;
	assign o_cmd_strobe = st.cmd_strobe;
	assign o_cmd = '{code: st.pk_cmd, param: st.pk_par[31:0]};
	assign o_prog_load = st.prog_load;
	assign o_prog_addr = st.prog_addr;
	assign o_prog_len = st.prog_len;
	assign o_last_status = st.status;
	assign o_link_lock = st.lock;

	// ==========================================================
	// checks
	default clocking sbl_cb @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);

	AST_LOCK_STICKY: assert property (st.lock != sbl_pkg::LK_NONE |=> st.lock == $past(st.lock))
		else $error("link lock changed after it was taken");
	AST_UART_START: assert property ($rose(st.utx_busy) |-> !o_uart_tx ##1 !o_uart_tx)
		else $error("start bit missing");
	AST_UART_STOP: assert property ($fell(st.utx_busy) |-> $past(o_uart_tx))
		else $error("stop bit not high");
	AST_BAUD_SET: assert property ((st.lock == sbl_pkg::LK_UART && $past(st.lock) == sbl_pkg::LK_NONE)
		|-> st.baud_div != 16'h0 && st.utx_cnt == 16'(st.baud_div - 16'h1))
		else $error("transmitter not at measured rate");
	AST_SYNC_CC: assert property ((st.lock == sbl_pkg::LK_UART && $past(st.lock) == sbl_pkg::LK_NONE)
		|-> st.utx_busy && st.utx_sh[8:1] == sbl_pkg::ACK_BYTE)
		else $error("sync confirmation not sent");
	AST_SHORT_NAK: assert property ((st.pk == sbl_pkg::E_SUM && f_take && st.pk_len < sbl_pkg::MIN_PKT_LEN)
		|=> st.pk == sbl_pkg::E_REPLY && eng_data == sbl_pkg::NAK_BYTE)
		else $error("short packet not refused");
	AST_SUM_NAK: assert property ((st.pk == sbl_pkg::E_DATA && f_take && st.pk_left == 8'h1 &&
		8'(st.pk_rsum + f_out_data) != st.pk_csum) |=> eng_valid && eng_data == sbl_pkg::NAK_BYTE)
		else $error("bad checksum not refused");
	AST_PING: assert property ((st.pk == sbl_pkg::E_REPLY && eng_take && !st.pk_bad &&
		st.pk_cmd == sbl_pkg::CMD_PING) |=> st.status == sbl_pkg::STAT_SUCCESS)
		else $error("ping did not set success");
	AST_STATUS_PKT: assert property ((st.pk == sbl_pkg::E_REPLY && eng_take && !st.pk_bad &&
		st.pk_cmd == sbl_pkg::CMD_STATUS) |=> st.pk == sbl_pkg::E_TSIZE &&
		eng_data == sbl_pkg::STATUS_PKT_LEN)
		else $error("status packet not started");
	AST_NO_GAP: assert property ((st.pk == sbl_pkg::E_TSIZE && eng_take) |=>
		eng_valid && eng_data == st.status && st.pk == sbl_pkg::E_TSUM)
		else $error("gap inside device packet");
	AST_ZERO_SKIP: assert property ((st.pk == sbl_pkg::E_WACK && f_take && f_out_data == sbl_pkg::PAD_BYTE)
		|=> st.pk == sbl_pkg::E_WACK)
		else $error("zero byte taken as reply");
	AST_UNKNOWN: assert property ((st.pk == sbl_pkg::E_REPLY && eng_take && !st.pk_bad &&
		!(st.pk_cmd inside {[sbl_pkg::CMD_PING:sbl_pkg::CMD_RESET]})) |=>
		st.status == sbl_pkg::STAT_UNKNOWN)
		else $error("unknown command not failed");
	AST_DL: assert property ((st.pk == sbl_pkg::E_REPLY && eng_take && !st.pk_bad &&
		st.pk_cmd == sbl_pkg::CMD_DOWNLOAD && st.pk_len == sbl_pkg::DL_PKT_LEN) |=>
		o_prog_load && o_prog_addr == $past(st.pk_par[63:32]))
		else $error("download address not captured");
endmodule

`default_nettype wire

// ### sbl_host_model.sv
// host side model of the boot link: async transmitter and byte receiver
// assumes the device tx line changes on i_core_clk rising edges; sampled on falling
`timescale 1ns/1ns
`default_nettype none

module sbl_host_model #(
	parameter int BIT = 40
) (
	input wire logic i_core_clk,
	input wire logic i_line_in,
	output logic o_line_out
);
	logic [7:0] rx_q[$];
	logic [7:0] sh;

	// idle high between characters, the level of a released async line
	initial begin
		o_line_out = 1'b1;
	end

	// ==========================================================
	// transmit: start, 8 data lsb first, no parity, one stop
	// bit time of 40 clocks keeps the rate under clock / 32
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		@(negedge i_core_clk);
		for (int i = 0; i < 10; i++) begin
			o_line_out = f[i];
			repeat (BIT) @(negedge i_core_clk);
		end
	endtask

	// ==========================================================
	// receive: free running so an answer overlapping our stop bit is kept
	// falling edge sampling keeps clear of the edge that launches the line
	always begin
		@(negedge i_core_clk);
		if (i_line_in === 1'b0) begin
			repeat (BIT / 2) @(negedge i_core_clk);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT) @(negedge i_core_clk);
				sh[i] = i_line_in;
			end
			repeat (BIT) @(negedge i_core_clk);
			// broken stop bit: hand back an unknown so the compare fails
			rx_q.push_back((i_line_in === 1'b1) ? sh : 8'hxx);
		end
	end

	// waits at most 40 bit times, twice the span of a sync pair
	task automatic recv_byte(output logic [7:0] b, output bit ok);
		int t;
		t = 0;
		while (rx_q.size() == 0 && t < 40 * BIT) begin
			@(posedge i_core_clk);
			t++;
		end
		ok = (rx_q.size() != 0);
		b = ok ? rx_q.pop_front() : 8'hxx;
	endtask
endmodule

`default_nettype wire

// ### testbench.sv
// self-checking bench for the boot link, host on the async port
// assumes sbl_pkg and sbl_link compiled first; host model drives rx
`timescale 1ns/1ns
`default_nettype none

module testbench;
	logic i_core_clk;
	logic i_nrst;
	logic i_ssi_clk;
	logic i_ssi_fss_n;
	logic i_ssi_mosi;
	wire logic rx_line;
	logic o_uart_tx;
	logic o_ssi_miso;
	logic o_ssi_miso_oe_n;
	logic o_cmd_strobe;
	sbl_pkg::sbl_cmd_t o_cmd;
	logic o_prog_load;
	logic [31:0] o_prog_addr;
	logic [31:0] o_prog_len;
	logic [7:0] o_last_status;
	sbl_pkg::sbl_lock_t o_link_lock;
	int err_total;
	int n_compared;
	int n_load = 0;
	int n_strobe = 0;
	sbl_pkg::sbl_cmd_t cmd_seen;

	sbl_link sbl_link_inst (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_uart_rx(rx_line),
		.o_uart_tx(o_uart_tx), .i_ssi_clk(i_ssi_clk), .i_ssi_fss_n(i_ssi_fss_n),
		.i_ssi_mosi(i_ssi_mosi), .o_ssi_miso(o_ssi_miso), .o_ssi_miso_oe_n(o_ssi_miso_oe_n),
		.o_cmd_strobe(o_cmd_strobe), .o_cmd(o_cmd), .o_prog_load(o_prog_load),
		.o_prog_addr(o_prog_addr), .o_prog_len(o_prog_len), .o_last_status(o_last_status),
		.o_link_lock(o_link_lock));

	sbl_host_model #(.BIT(40)) sbl_host_model_inst (.i_core_clk(i_core_clk),
		.i_line_in(o_uart_tx), .o_line_out(rx_line));

	// ==========================================================
	// clock, pulse counters
	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end

	always @(posedge i_core_clk) begin
		if (o_prog_load === 1'b1) n_load <= n_load + 1;
		if (o_cmd_strobe === 1'b1) begin
			n_strobe <= n_strobe + 1;
			cmd_seen <= o_cmd;
		end
	end

	// ==========================================================
	// shared tasks
	task automatic chk_val(input logic [39:0] got, input logic [39:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// first non-zero byte is the answer; zeros are padding
	task automatic expect_byte(input logic [7:0] exp);
		logic [7:0] b;
		bit ok;
		b = 8'h00;
		ok = 1'b1;
		while (ok && b === 8'h00) sbl_host_model_inst.recv_byte(b, ok);
		chk_val(40'(b), 40'(exp));
	endtask

	// length, payload sum plus skew (nonzero skew forces a bad sum), payload
	task automatic send_cmd(input logic [7:0] p[$], input logic [7:0] skew);
		logic [7:0] s;
		s = skew;
		foreach (p[i]) s = s + p[i];
		sbl_host_model_inst.send_byte(8'(p.size() + 2));
		sbl_host_model_inst.send_byte(s);
		foreach (p[i]) sbl_host_model_inst.send_byte(p[i]);
	endtask

	task automatic end_of_test;
		if (err_total == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ==========================================================
	// scenarios
	task automatic t_sync;
		logic [7:0] b;
		bit ok;
		ok = 1'b0;
		for (int k = 0; k < 2 && !ok; k++) begin
			sbl_host_model_inst.send_byte(8'h55);
			sbl_host_model_inst.send_byte(8'h55);
			sbl_host_model_inst.recv_byte(b, ok);
		end
		chk_val(40'(b), 40'(sbl_pkg::ACK_BYTE));
		chk_val(40'(o_link_lock), 40'(sbl_pkg::LK_UART));
	endtask

	task automatic t_ping;
		send_cmd('{8'h20}, 8'h00);
		expect_byte(sbl_pkg::ACK_BYTE);
		chk_val(40'(o_last_status), 40'(sbl_pkg::STAT_SUCCESS));
	endtask

	task automatic t_unknown;
		send_cmd('{8'h2f}, 8'h00);
		expect_byte(sbl_pkg::ACK_BYTE);
		chk_val(40'(o_last_status), 40'(sbl_pkg::STAT_UNKNOWN));
	endtask

	// a ping with a wrong sum must not reach the status
	task automatic t_bad_sum;
		send_cmd('{8'h20}, 8'h01);
		expect_byte(sbl_pkg::NAK_BYTE);
		chk_val(40'(o_last_status), 40'(sbl_pkg::STAT_UNKNOWN));
	endtask

	task automatic t_short;
		sbl_host_model_inst.send_byte(8'h02);
		sbl_host_model_inst.send_byte(8'h00);
		expect_byte(sbl_pkg::NAK_BYTE);
	endtask

	task automatic t_status;
		send_cmd('{sbl_pkg::CMD_STATUS}, 8'h00);
		expect_byte(sbl_pkg::ACK_BYTE);
		expect_byte(8'h03);
		expect_byte(sbl_pkg::STAT_UNKNOWN);
		expect_byte(sbl_pkg::STAT_UNKNOWN);
		sbl_host_model_inst.send_byte(8'h00);
		sbl_host_model_inst.send_byte(sbl_pkg::ACK_BYTE);
		chk_val(40'(o_last_status), 40'(sbl_pkg::STAT_UNKNOWN));
	endtask

	// leading zero padding before the length byte
	task automatic t_download;
		sbl_host_model_inst.send_byte(8'h00);
		send_cmd('{8'h21, 8'ha1, 8'hb2, 8'hc3, 8'hd4, 8'h00, 8'h01, 8'h02, 8'h80}, 8'h00);
		expect_byte(sbl_pkg::ACK_BYTE);
		chk_val(40'(n_load), 40'h1);
		chk_val(40'(o_prog_addr), 40'ha1b2c3d4);
		chk_val(40'(o_prog_len), 40'h00010280);
		chk_val(40'(o_last_status), 40'(sbl_pkg::STAT_SUCCESS));
		send_cmd('{sbl_pkg::CMD_DOWNLOAD}, 8'h00);
		expect_byte(sbl_pkg::ACK_BYTE);
		chk_val(40'(n_load), 40'h1);
		chk_val(40'(o_last_status), 40'(sbl_pkg::STAT_BAD_LEN));
	endtask

	task automatic t_run;
		send_cmd('{sbl_pkg::CMD_RUN, 8'h12, 8'h34, 8'h56, 8'h78}, 8'h00);
		expect_byte(sbl_pkg::ACK_BYTE);
		chk_val(40'(n_strobe), 40'h1);
		chk_val(cmd_seen, 40'h2212345678);
		send_cmd('{sbl_pkg::CMD_SEND_DATA, 8'h9a}, 8'h00);
		expect_byte(sbl_pkg::ACK_BYTE);
		send_cmd('{sbl_pkg::CMD_RESET}, 8'h00);
		expect_byte(sbl_pkg::ACK_BYTE);
		chk_val(40'(n_strobe), 40'h3);
		chk_val(cmd_seen, 40'h253456789a);
	endtask

	// sync port framed while async owns the link: must stay silent
	task automatic t_ssi_locked;
		logic [7:0] v;
		v = 8'h03;
		@(negedge i_core_clk);
		i_ssi_fss_n = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			repeat (6) @(negedge i_core_clk);
			i_ssi_clk = 1'b0;
			i_ssi_mosi = v[i];
			repeat (6) @(negedge i_core_clk);
			i_ssi_clk = 1'b1;
			chk_val(40'(o_ssi_miso_oe_n), 40'h1);
		end
		repeat (6) @(negedge i_core_clk);
		i_ssi_fss_n = 1'b1;
		i_ssi_mosi = ~i_ssi_mosi;
		chk_val(40'(o_link_lock), 40'(sbl_pkg::LK_UART));
	endtask

	// one mode 3 byte, 12 clocks a bit; frame left open for the next byte
	task automatic ssi_xfer(input logic [7:0] v, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			@(negedge i_core_clk);
			i_ssi_fss_n = 1'b0;
			i_ssi_clk = 1'b0;
			i_ssi_mosi = v[i];
			repeat (6) @(negedge i_core_clk);
			r[i] = o_ssi_miso;
			i_ssi_clk = 1'b1;
			repeat (5) @(negedge i_core_clk);
		end
	endtask

	// after a fresh reset the sync port takes the link and answers a ping
	task automatic t_ssi_ping;
		logic [7:0] r;
		ssi_xfer(8'h03, r);
		ssi_xfer(sbl_pkg::CMD_PING, r);
		ssi_xfer(sbl_pkg::CMD_PING, r);
		chk_val(40'(r), 40'(sbl_pkg::PAD_BYTE));
		chk_val(40'(o_ssi_miso_oe_n), 40'h0);
		for (int k = 0; k < 4 && r === 8'h00; k++) ssi_xfer(sbl_pkg::PAD_BYTE, r);
		chk_val(40'(r), 40'(sbl_pkg::ACK_BYTE));
		chk_val(40'(o_link_lock), 40'(sbl_pkg::LK_SSI));
		chk_val(40'(o_last_status), 40'(sbl_pkg::STAT_SUCCESS));
		@(negedge i_core_clk);
		i_ssi_fss_n = 1'b1;
	endtask

	// ==========================================================
	// main sequence and watchdog
	initial begin
		err_total = 0;
		n_compared = 0;
		i_nrst = 1'b0;
		i_ssi_clk = 1'b1;
		i_ssi_fss_n = 1'b1;
		i_ssi_mosi = 1'b0;
		repeat (3) @(negedge i_core_clk);
		i_nrst = 1'b1;
		chk_val(40'(o_link_lock), 40'(sbl_pkg::LK_NONE));
		t_sync();
		t_ping();
		t_unknown();
		t_bad_sum();
		t_short();
		t_status();
		t_download();
		t_run();
		t_ssi_locked();
		t_ping();
		// second reset frees the lock for the sync port
		@(negedge i_core_clk);
		i_nrst = 1'b0;
		repeat (3) @(negedge i_core_clk);
		i_nrst = 1'b1;
		chk_val(40'(o_link_lock), 40'(sbl_pkg::LK_NONE));
		chk_val(40'(o_ssi_miso_oe_n), 40'h1);
		t_ssi_ping();
		end_of_test();
	end

	// about 60 characters of 400 clocks each, with a wide margin
	initial begin
		repeat (90000) @(posedge i_core_clk);
		err_total++;
		end_of_test();
	end
endmodule

`default_nettype wire
